/* rtl/pmt_table_access.sv */
//Behaviour
//- A table read fetches the pointed program byte into the data latch.
//- The table byte pointer is 21 bits and addresses single bytes.
//- Every pointer value in the two-megabyte span picks a distinct byte.
//- Pointer bit zero picks low byte (0) or high byte (1) of a word.
//- Reads support none, post-inc, post-dec, pre-inc; pre-inc before fetch.
//- A table write copies the latch into holding register pointer[2:0].
//- Writes only load holding registers; program memory is not changed.
//- Write with no-change mode loads holding register, pointer kept.
//- Write post-increment loads with current pointer, then adds one.
//- Write post-decrement loads with current pointer, then subtracts one.
//- Write pre-increment adds one first, then loads by new pointer.
`timescale 1ns/1ps

// Executes table reads and table writes for the core. A read fetches one
// program memory byte into the latch; a write copies the latch into one
// of the holding registers. Both may step the pointer.
module pmt_table_access
    import pmt_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic                  clk_i,                // Core clock.
    input  wire logic                  sys_rst_i,            // Sync reset.
    input  wire logic                  ce_i,                 // Clock enable.
    // Operation requests.
    input  wire logic                  table_read_op_i,      // Start a read.
    input  wire logic                  table_write_op_i,     // Start a write.
    input  wire logic [1:0]            mode_i,               // Step mode.
    // Core access to pointer and latch.
    input  wire logic                  ptr_load_i,           // Load pointer.
    input  wire logic [PTR_W-1:0]      ptr_data_i,           // Pointer value.
    input  wire logic                  latch_load_i,         // Load latch.
    input  wire logic [DATA_W-1:0]     latch_data_i,         // Latch value.
    // Program memory and holding readback.
    input  wire logic [DATA_W-1:0]     pm_rdata_i,           // Memory byte.
    input  wire logic [HOLD_IDX_W-1:0] hold_sel_i,           // Readback pick.
    // Program memory access.
    output logic [PTR_W-1:0]           pm_addr_o,            // Byte address.
    output logic                       pm_rd_o,              // Memory read.
    // Core-visible state and status.
    output logic [PTR_W-1:0]           table_byte_pointer_o, // Pointer.
    output logic [DATA_W-1:0]          table_data_latch_o,   // Latch.
    output logic [DATA_W-1:0]          hold_data_o,          // Readback.
    output logic                       busy_o,               // Execute cycle.
    output logic                       done_o                // Done pulse.
);

    // Adds or subtracts one from a pointer, wrapping at either end.
    function automatic logic [PTR_W-1:0] ptr_step(
        input logic [PTR_W-1:0] p,
        input logic             dec
    );
        ptr_step = dec ? (p - PTR_ONE) : (p + PTR_ONE);
    endfunction

    // Read has priority, so a request is a write only with read low.
    function automatic logic req_is_write(
        input logic rd,
        input logic wr
    );
        req_is_write = wr && !rd;
    endfunction

    // True for the mode that steps the pointer before the access.
    function automatic logic mode_is_pre(
        input logic [1:0] m
    );
        mode_is_pre = (m == MODE_PRE_INC);
    endfunction

    // True for the two modes that step the pointer after the access.
    function automatic logic mode_is_post(
        input logic [1:0] m
    );
        mode_is_post = (m == MODE_POST_INC) || (m == MODE_POST_DEC);
    endfunction

    // True for the mode that steps the pointer down rather than up.
    function automatic logic mode_is_dec(
        input logic [1:0] m
    );
        mode_is_dec = (m == MODE_POST_DEC);
    endfunction

    // Picks the holding register from the low bits of a byte address.
    function automatic logic [HOLD_IDX_W-1:0] hold_index(
        input logic [PTR_W-1:0] a
    );
        hold_index = a[HOLD_IDX_W-1:0];
    endfunction

    // Sequencer state and the registers behind every output but hold_data_o.
    pmt_state_e        state_q, state_d;
    logic              is_write_q;
    logic [1:0]        mode_q;
    logic [PTR_W-1:0]  ptr_q, ptr_d;
    logic [DATA_W-1:0] latch_q, latch_d;
    logic [PTR_W-1:0]  addr_q, addr_d;
    logic              rd_q;
    logic              busy_q;
    logic              done_q;

    // Sequencer phase decode.
    wire idle_w    = (state_q == PMT_IDLE);
    wire exec_w    = (state_q == PMT_EXEC);
    wire exec_nx_w = (state_d == PMT_EXEC);

    // A request is taken only while idle. If both operations are raised
    // together the read wins, so the write flag needs the read low.
    wire req_w      = table_read_op_i | table_write_op_i;
    wire start_w    = req_w && idle_w;
    wire start_rd_w = start_w && table_read_op_i;
    wire start_wr_w = start_w && req_is_write(table_read_op_i,
                                              table_write_op_i);

    // Core writes to pointer and latch are refused during the execute
    // cycle, so an access always works on a stable pointer and latch.
    wire ptr_load_w   = ptr_load_i && idle_w;
    wire latch_load_w = latch_load_i && idle_w;

    // Mode decode of the request in hand and of the captured request.
    wire pre_inc_w  = mode_is_pre(mode_i);
    wire post_w     = mode_is_post(mode_q);
    wire post_dec_w = mode_is_dec(mode_q);

    // Access address: pre-increment uses the stepped pointer so that the
    // fetch or the holding load already sees the new value.
    wire [PTR_W-1:0] ptr_inc_w  = ptr_step(ptr_q, 1'b0);
    wire [PTR_W-1:0] ptr_post_w = ptr_step(ptr_q, post_dec_w);
    wire [PTR_W-1:0] acc_addr_w = pre_inc_w ? ptr_inc_w
                                            : ptr_q;

    // Operation kind during the execute cycle.
    wire rd_exec_w = exec_w && !is_write_q;
    wire wr_exec_w = exec_w && is_write_q;

    // The three low address bits pick the holding register.
    wire [HOLD_IDX_W-1:0] hold_idx_w = hold_index(addr_q);

    // Sequencer: cycle one decodes, cycle two performs the access.
    always_comb begin
        state_d = state_q;
        case (state_q)
            PMT_IDLE: begin
                if (start_w) begin
                    state_d = PMT_EXEC;
                end
            end
            PMT_EXEC: begin
                state_d = PMT_IDLE;
            end
            default: begin
                state_d = PMT_IDLE;
            end
        endcase
    end

    // Pointer update. Pre-increment is applied as the request is taken so
    // the access sees the new value; the post modes step once the access
    // in the execute cycle is done. A core load waits for idle.
    always_comb begin
        ptr_d = ptr_q;
        if (start_w && pre_inc_w) begin
            ptr_d = ptr_inc_w;
        end else if (exec_w && post_w) begin
            ptr_d = ptr_post_w;
        end else if (exec_w) begin
            ptr_d = ptr_q;
        end else if (ptr_load_w) begin
            ptr_d = ptr_data_i;
        end
    end

    // The access address is captured as the request is taken and stands
    // until the next request.
    always_comb begin
        addr_d = addr_q;
        if (start_w) begin
            addr_d = acc_addr_w;
        end
    end

    // Latch takes the fetched byte at the end of a read; bit zero of the
    // address has already chosen the low or high byte of the word.
    always_comb begin
        latch_d = latch_q;
        if (rd_exec_w) begin
            latch_d = pm_rdata_i;
        end else if (latch_load_w) begin
            latch_d = latch_data_i;
        end
    end

    // Sequencer state register. A low clock enable freezes it, and with
    // it the whole operation, in place.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= PMT_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // Table byte pointer: a full byte address, so every value in the
    // two-megabyte span names its own byte.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ptr_q <= PTR_RST;
        end else if (ce_i) begin
            ptr_q <= ptr_d;
        end
    end

    // Table data latch: written by a read or by the core while idle.
    // A write only reads it.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            latch_q <= LATCH_RST;
        end else if (ce_i) begin
            latch_q <= latch_d;
        end
    end

    // Program memory address register; it stands from one request to
    // the next so the memory sees a steady address.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            addr_q <= PTR_RST;
        end else if (ce_i) begin
            addr_q <= addr_d;
        end
    end

    // Operation kind, captured as the request is taken. It steers the
    // execute cycle to the fetch or to the holding load.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            is_write_q <= 1'b0;
        end else if (ce_i) begin
            if (start_w) begin
                is_write_q <= start_wr_w;
            end
        end
    end

    // Step mode, captured as the request is taken, so that a mode input
    // that moves during the execute cycle cannot change the post step.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_q <= MODE_NONE;
        end else if (ce_i) begin
            if (start_w) begin
                mode_q <= mode_i;
            end
        end
    end

    // Memory read strobe: high only in the execute cycle of a read,
    // including a read raised together with a write.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_q <= 1'b0;
        end else if (ce_i) begin
            rd_q <= start_rd_w;
        end
    end

    // Busy flag, registered so the output comes from a flop; it is high
    // exactly while the sequencer is in its execute cycle.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0;
        end else if (ce_i) begin
            busy_q <= exec_nx_w;
        end
    end

    // Completion pulse after the second cycle. No status flags exist, so
    // none can change.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_q <= 1'b0;
        end else if (ce_i) begin
            done_q <= exec_w;
        end
    end

    // Holding registers; only written here, never program memory. They
    // hold the data for a later programming operation.
    pmt_hold_regs u_hold (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .wr_i      (wr_exec_w),
        .wr_idx_i  (hold_idx_w),
        .wr_data_i (latch_q),
        .rd_idx_i  (hold_sel_i),
        .rd_data_o (hold_data_o)
    );

    // Outputs straight from flip-flops; the readback register sits in the
    // holding module.
    assign pm_addr_o            = addr_q;
    assign pm_rd_o              = rd_q;
    assign table_byte_pointer_o = ptr_q;
    assign table_data_latch_o   = latch_q;
    assign busy_o               = busy_q;
    assign done_o               = done_q;

endmodule

/* inc/pmt_pkg.sv */
package pmt_pkg;

    // Table byte pointer width and derived spans.
    localparam int PTR_W     = 21;
    localparam int DATA_W    = 8;
    localparam int HOLD_N    = 8;
    localparam int HOLD_IDX_W = 3;

    // Pointer-update encodings of the two-bit mode field.
    localparam logic [1:0] MODE_NONE     = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC  = 2'h3;

    // Reset values and the unit pointer step.
    localparam logic [PTR_W-1:0]  PTR_RST   = 21'h000000;
    localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
    localparam logic [DATA_W-1:0] HOLD_RST  = 8'hff;
    localparam logic [PTR_W-1:0]  PTR_ONE   = 21'h000001;

    // Sequencer states.
    typedef enum logic [1:0] {
        PMT_IDLE,
        PMT_EXEC
    } pmt_state_e;

endpackage

/* rtl/pmt_hold_regs.sv */
`timescale 1ns/1ps

// Eight write holding registers with a registered read port.
module pmt_hold_regs
    import pmt_pkg::*;
(
    input  wire logic                  clk_i,     // Core clock.
    input  wire logic                  sys_rst_i, // Synchronous reset.
    input  wire logic                  ce_i,      // Clock enable.
    input  wire logic                  wr_i,      // Write strobe.
    input  wire logic [HOLD_IDX_W-1:0] wr_idx_i,  // Write index.
    input  wire logic [DATA_W-1:0]     wr_data_i, // Write data.
    input  wire logic [HOLD_IDX_W-1:0] rd_idx_i,  // Read index.
    output logic      [DATA_W-1:0]     rd_data_o  // Registered read data.
);

    logic [DATA_W-1:0] mem_q [HOLD_N];

    // Write one entry and register the read word each cycle.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < HOLD_N; i++) begin
                mem_q[i] <= HOLD_RST;
            end
            rd_data_o <= HOLD_RST;
        end else if (ce_i) begin
            if (wr_i) begin
                mem_q[wr_idx_i] <= wr_data_i;
            end
            rd_data_o <= mem_q[rd_idx_i];
        end
    end

endmodule

/* testbench/pmt_mem_model.sv */
`timescale 1ns/1ps

// Program memory byte source; the byte is the XOR of the three address bytes.
module pmt_mem_model
    import pmt_pkg::*;
(
    input  wire logic [PTR_W-1:0]  addr_i, // Byte address.
    input  wire logic              rd_i,   // Read strobe.
    output logic      [DATA_W-1:0] data_o  // Read byte.
);
    // Idle lines show the inverse, so a late sample never matches.
    wire logic [DATA_W-1:0] byte_w = addr_i[7:0] ^ addr_i[15:8]
        ^ {3'h0, addr_i[20:16]};
    assign data_o = rd_i ? byte_w : ~byte_w;
endmodule

/* testbench/pmt_table_access_assertions.sv */
`timescale 1ns/1ps

// Watches the timing and pointer stepping of table operations.
module pmt_chk
    import pmt_pkg::*;
(
    input wire logic              clk_i,                // Clock.
    input wire logic              sys_rst_i,            // Reset.
    input wire logic              ce_i,                 // Clock enable.
    input wire logic              table_read_op_i,      // Read start.
    input wire logic              table_write_op_i,     // Write start.
    input wire logic [1:0]        mode_i,               // Step mode.
    input wire logic [DATA_W-1:0] pm_rdata_i,           // Memory byte.
    input wire logic [PTR_W-1:0]  pm_addr_o,            // Address.
    input wire logic              pm_rd_o,              // Read strobe.
    input wire logic [PTR_W-1:0]  table_byte_pointer_o, // Pointer.
    input wire logic [DATA_W-1:0] table_data_latch_o,   // Latch.
    input wire logic              busy_o,               // Busy.
    input wire logic              done_o                // Done.
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || !ce_i);
    // A request is only taken while the sequencer is idle.
    wire logic req = table_read_op_i | table_write_op_i;
    wire logic st = req & ~busy_o;
    wire logic [PTR_W-1:0] p = table_byte_pointer_o;
    AST_TWO_CYC:
        assert property (st |=> busy_o ##1 (!busy_o && done_o))
        else $error("operation length wrong");
    AST_REFUSE:
        assert property (req && busy_o |=> !busy_o)
        else $error("request taken while busy");
    AST_PM_RD:
        assert property (st |=> pm_rd_o == $past(table_read_op_i))
        else $error("memory read strobe wrong");
    AST_PRE_INC:
        assert property (st && mode_i == MODE_PRE_INC |=> pm_addr_o ==
            $past(p) + PTR_ONE ##1 p == $past(p, 2) + PTR_ONE)
        else $error("pre-increment wrong");
    AST_POST_INC:
        assert property (st && mode_i == MODE_POST_INC |=> pm_addr_o ==
            $past(p) ##1 p == $past(p, 2) + PTR_ONE)
        else $error("post-increment wrong");
    AST_POST_DEC:
        assert property (st && mode_i == MODE_POST_DEC |=> pm_addr_o ==
            $past(p) ##1 p == $past(p, 2) - PTR_ONE)
        else $error("post-decrement wrong");
    AST_NO_CHG:
        assert property (st && mode_i == MODE_NONE |=> ##1 p == $past(p, 2))
        else $error("pointer changed");
    AST_LATCH:
        assert property (st && table_read_op_i |=> ##1
            table_data_latch_o == $past(pm_rdata_i))
        else $error("latch not loaded");
    // Main scenarios.
    cover property (st && table_read_op_i && mode_i == MODE_PRE_INC);
    cover property (st && !table_read_op_i);
    cover property (req && busy_o);
endmodule

bind pmt_table_access pmt_chk u_chk (.*);

/* testbench/program_memory_table_access_bench.sv */
`timescale 1ns/1ps

// Runs table reads and writes in every step mode and checks the results.
module program_memory_table_access_bench
    import pmt_pkg::*;
;
    logic              clk_i = 1'b0, sys_rst_i = 1'b1, ld = 1'b0;
    logic              ce = 1'b1;
    logic              rd_op = 1'b0, wr_op = 1'b0, pm_rd, busy, done;
    logic [1:0]        mode = 2'h0;
    logic [PTR_W-1:0]  ptr_d = '0, addr, ptr;
    logic [DATA_W-1:0] lat_d = '0, rdata, latch, hold;
    logic [2:0]        sel = 3'h0;
    int                n_errors = 0, checks = 0;
    localparam logic [PTR_W-1:0] RD_P [4] = '{21'h00a356, 21'h1fffff,
        21'h000000, 21'h01a357};

    pmt_table_access dut (.clk_i, .sys_rst_i, .ce_i(ce),
        .table_read_op_i(rd_op), .table_write_op_i(wr_op), .mode_i(mode),
        .ptr_load_i(ld), .ptr_data_i(ptr_d), .latch_load_i(ld),
        .latch_data_i(lat_d), .pm_rdata_i(rdata), .hold_sel_i(sel),
        .pm_addr_o(addr), .pm_rd_o(pm_rd), .table_byte_pointer_o(ptr),
        .table_data_latch_o(latch), .hold_data_o(hold), .busy_o(busy),
        .done_o(done));
    pmt_mem_model u_mem (.addr_i(addr), .rd_i(pm_rd), .data_o(rdata));

    // Clock and watchdog.
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        #20000;
        n_errors++;
        close_out();
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic chk(input string nm, input logic [PTR_W-1:0] e, g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [PTR_W-1:0] step(logic [PTR_W-1:0] p, int m);
        return m == 0 ? p : m == 2 ? p - PTR_ONE : p + PTR_ONE;
    endfunction
    // Loads pointer and latch while idle.
    task automatic load(input logic [PTR_W-1:0] p, input logic [7:0] l);
        ptr_d = p;
        lat_d = l;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
    endtask
    // Holds the request over the busy edge too, where it must be refused.
    task automatic op(input logic r, input logic [1:0] m);
        rd_op = r;
        wr_op = ~r;
        mode = m;
        tick(2);
        rd_op = 1'b0;
        wr_op = 1'b0;
        chk("done", 1'b1, done);
    endtask

    task automatic t_reset;
        tick(4);
        sys_rst_i = 1'b0;
        chk("pointer", PTR_RST, ptr);
        chk("latch", LATCH_RST, latch);
        chk("holding", HOLD_RST, hold);
        $display("test reset done");
    endtask
    task automatic t_read;
        logic [PTR_W-1:0] p, a;
        for (int m = 0; m < 4; m++) begin
            p = RD_P[m];
            a = (m == 3) ? p + PTR_ONE : p;
            load(p, 8'h00);
            op(1'b1, 2'(m));
            chk("latch", a[7:0] ^ a[15:8] ^ a[20:16], latch);
            chk("pointer", step(p, m), ptr);
        end
        $display("test read done");
    endtask
    task automatic t_write;
        logic [PTR_W-1:0] p;
        for (int m = 0; m < 4; m++) begin
            p = 21'h00a350 + 21'(m);
            load(p, 8'h30 + 8'(m));
            op(1'b0, 2'(m));
            chk("pointer", step(p, m), ptr);
            sel = (m == 3) ? 3'(p + PTR_ONE) : p[2:0];
            tick(2);
            chk("holding", 8'h30 + 8'(m), hold);
        end
        sel = 3'h7;
        tick(2);
        chk("untouched holding", HOLD_RST, hold);
        $display("test write done");
    endtask

    // Read wins over write, a low enable freezes a running read, and
    // loads raised in its execute cycle are refused.
    task automatic t_misc;
        load(21'h00a356, 8'h5a);
        rd_op = 1'b1;
        wr_op = 1'b1;
        mode = MODE_POST_INC;
        tick(1);
        rd_op = 1'b0;
        wr_op = 1'b0;
        ce = 1'b0;
        ptr_d = 21'h000777;
        ld = 1'b1;
        tick(3);
        chk("frozen pointer", 21'h00a356, ptr);
        chk("frozen busy", 1'b1, busy);
        ce = 1'b1;
        tick(1);
        ld = 1'b0;
        chk("pointer", 21'h00a357, ptr);
        chk("latch", 8'hf5, latch);
        chk("done", 1'b1, done);
        sel = 3'h6;
        tick(2);
        chk("holding", HOLD_RST, hold);
        $display("test misc done");
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        t_reset();
        t_read();
        t_write();
        t_misc();
        close_out();
    end
endmodule
